// file: pin_edge_sampler.sv
// Purpose: Synchronise one pin and report edges at a sampling enable
// Assumes: Pin is asynchronous to CLOCK_IN
// Notes:   Edges are one-cycle pulses in the cycle after sample_en_in
`timescale 1ns/10ps
`default_nettype none
module pin_edge_sampler (
	input  wire logic clk_in,        // System clock
	input  wire logic srst_in,       // Synchronous reset
	input  wire logic pin_in,        // Raw pin level
	input  wire logic sample_en_in,  // Sampling strobe
	output var  logic rise_out,      // Rising edge seen
	output var  logic fall_out       // Falling edge seen
);
	logic sync_a;                    // First synchroniser stage
	logic sync_b;                    // Second synchroniser stage
	logic sampled;                   // Level at last sampling strobe

	// Two-stage synchroniser
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			sync_a <= pin_in;
			sync_b <= sync_a;
		end
	end

	// Sample on strobe and compare with the previous sample
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sampled  <= 1'b0;
			rise_out <= 1'b0;
			fall_out <= 1'b0;
		end else begin
			rise_out <= sample_en_in & sync_b & ~sampled;
			fall_out <= sample_en_in & ~sync_b & sampled;
			if (sample_en_in) begin
				sampled <= sync_b;
			end
		end
	end
endmodule
`default_nettype wire

// file: pwm_channel_control.sv
// Purpose: Control registers and count/output logic of one 16-bit PWM channel
// Assumes: Period and duty values come from registers outside this block
// Notes:   Registers sit on Avalon-MM; one wait cycle per access
//
// Contract
// - Clear-inhibit gates external clear while flag high
// - Coupled mode uses partner clear-inhibit
// - Suspension holds level or returns initial
// - Coupled: suspend select only when partner stopped
// - Initial level bit, inverted by negative polarity
// - Polarity bit selects positive or negative logic
// - Interrupt point: period, duty, or both
// - Clock select: low-speed, oscillator, external pin
// - Triggers sampled by oscillator or low-speed clock
// - Status bit shows counting, resets to zero
// - Output flag readable, set by counter write
// - Run bit starts and stops counting
// - One-shot runs one period then stops
// - Trigger pin select picks event input
// - Start mode field selects start source
// - Coupled mode ignores start mode and edge
// - External start edge start/stop behaviour
// - External clear edge selection
// - Counter byte write clears counter
// - Coupled mode uses partner divider setting
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module pwm_channel_control
	import pwm_channel_pkg::*;
(
	input  wire logic              CLOCK_IN,                 // 250 MHz system clock
	input  wire logic              SRST_IN,                  // Synchronous reset
	input  wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,           // Byte address
	input  wire logic              AVS_READ_IN,              // Read request
	input  wire logic              AVS_WRITE_IN,             // Write request
	input  wire logic [31:0]       AVS_WRITEDATA_IN,         // Write data
	input  wire logic [3:0]        AVS_BYTEENABLE_IN,        // Byte lanes
	output var  logic [31:0]       AVS_READDATA_OUT,         // Read data
	output var  logic              AVS_WAITREQUEST_OUT,      // Slave busy
	input  wire logic [15:0]       PERIOD_IN,                // Period value
	input  wire logic [15:0]       DUTY_IN,                  // Duty value
	input  wire logic [2:0]        DIVIDER_SELECT_IN,        // Own divider code
	input  wire logic              EVENT_INPUT_ZERO_IN,      // Event pin 0
	input  wire logic              EVENT_INPUT_ONE_IN,       // Event pin 1
	input  wire logic              EXTERNAL_TIMER_CLOCK_PIN_IN, // External clock pin
	input  wire logic              PAIR_COUPLED_MODE_IN,     // Pair coupled
	input  wire logic              PARTNER_CLEAR_INHIBIT_IN, // Partner clear-inhibit
	input  wire logic              PARTNER_RUN_IN,           // Partner run bit
	input  wire logic              PARTNER_ONE_SHOT_IN,      // Partner one-shot
	input  wire logic              PARTNER_TRIGGER_PIN_IN,   // Partner pin select
	input  wire logic [2:0]        PARTNER_DIVIDER_IN,       // Partner divider code
	output var  logic              PWM_OUT,                  // PWM output pin
	output var  logic              IRQ_OUT,                  // Interrupt pulse
	output var  logic              COUNTING_OUT              // Counting status
);

	// Register index of a word-aligned byte address
	function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
		reg_index = addr[ADDR_W-1:2];
	endfunction

	// Interrupt on a compare event for the selected point
	function automatic logic irq_hit(input logic [1:0] sel, input logic per,
		input logic dut);
		irq_hit = sel[1] ? (per | dut) : (sel[0] ? dut : per);
	endfunction

	logic [7:0]   config_reg;          // pwm_b_config
	logic         run_control;         // Software run bit
	logic [7:0]   trig_reg;            // pwm_b_trigger_mode
	logic         output_flag;         // Internal output level
	count_state_e state;               // Counting state
	logic [15:0]  counter;             // 16-bit binary counter
	logic [7:0]   ls_cnt;              // Low-speed enable divider
	logic [7:0]   osc_cnt;             // Oscillator enable divider
	logic         ls_en;               // Low-speed clock enable
	logic         osc_en;              // Oscillator clock enable
	logic [6:0]   prescale;            // Operating clock prescaler
	logic [NUM_PINS-1:0] pin_raw;      // Pins to synchronise
	logic [NUM_PINS-1:0] pin_smp;      // Sampling strobes
	logic [NUM_PINS-1:0] pin_rise;     // Rising edges
	logic [NUM_PINS-1:0] pin_fall;     // Falling edges
	logic         bus_req;             // Read or write pending
	logic         bus_go;              // Access completes this edge
	logic         wr_go;               // Write completes this edge
	logic [IDX_W-1:0] bus_idx;         // Decoded index
	logic [7:0]   rd_byte;             // Read mux result
	logic         cnt_write;           // Counter byte written
	logic [1:0]   clk_sel;             // Clock source field
	logic         src_en;              // Selected source enable
	logic [2:0]   div_eff;             // Effective divider code
	logic [6:0]   div_mask;            // Prescaler terminal mask
	logic         tick;                // Counting tick
	logic         trig_sel_eff;        // Effective pin select
	logic         trig_rise;           // Trigger rising edge
	logic         trig_fall;           // Trigger falling edge
	logic [1:0]   stm_eff;             // Effective start mode
	logic [1:0]   edge_eff;            // Effective edge field
	logic         clr_inh_eff;         // Effective clear-inhibit
	logic         one_shot_eff;        // Effective one-shot
	logic         ext_start;           // External start event
	logic         ext_stop;            // External stop and clear event
	logic         ext_clear;           // External clear event
	logic         susp_return;         // Return to initial when stopped
	logic         init_out;            // Initial pin level
	logic         per_match;           // Period compare
	logic         duty_match;          // Duty compare
	logic         counting;            // State is counting
	logic         sw_start;            // Software writes run=1
	logic         sw_stop;             // Software writes run=0

	// Bus decode
	assign bus_req   = AVS_READ_IN | AVS_WRITE_IN;
	assign bus_go    = bus_req & ~AVS_WAITREQUEST_OUT;
	assign wr_go     = bus_go & AVS_WRITE_IN & AVS_BYTEENABLE_IN[0];
	assign bus_idx   = reg_index(AVS_ADDRESS_IN);
	assign cnt_write = wr_go & ((bus_idx == IDX_COUNT_LO) | (bus_idx == IDX_COUNT_HI));
	assign sw_start  = wr_go & (bus_idx == IDX_RUN_STAT) & AVS_WRITEDATA_IN[B_RUN];
	assign sw_stop   = wr_go & (bus_idx == IDX_RUN_STAT) & ~AVS_WRITEDATA_IN[B_RUN];
	assign counting  = (state == ST_COUNTING);

	// Coupled-mode selection of effective settings
	assign clr_inh_eff  = PAIR_COUPLED_MODE_IN ? PARTNER_CLEAR_INHIBIT_IN
		: config_reg[B_CLR_INH];
	assign one_shot_eff = PAIR_COUPLED_MODE_IN ? PARTNER_ONE_SHOT_IN : trig_reg[B_ONE_SHOT];
	assign trig_sel_eff = PAIR_COUPLED_MODE_IN ? PARTNER_TRIGGER_PIN_IN
		: trig_reg[B_TRIG_PIN];
	assign stm_eff  = PAIR_COUPLED_MODE_IN ? STM_SW : trig_reg[B_STM_HI:B_STM_LO];
	assign edge_eff = PAIR_COUPLED_MODE_IN ? EDGE_OFF
		: trig_reg[B_EDGE_HI:B_EDGE_LO];
	assign div_eff  = PAIR_COUPLED_MODE_IN ? PARTNER_DIVIDER_IN : DIVIDER_SELECT_IN;

	// Suspension level: coupled channel follows partner run bit
	assign susp_return = config_reg[B_SUSP_LVL]
		& (~PAIR_COUPLED_MODE_IN | ~PARTNER_RUN_IN);

	// Initial level high for zero, inverted by negative logic
	assign init_out = ~(config_reg[B_INIT_LVL] ^ config_reg[B_POLARITY]);

	// Low-speed and oscillator enables from the system clock
	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			ls_cnt  <= 8'h00;
			osc_cnt <= 8'h00;
			ls_en   <= 1'b0;
			osc_en  <= 1'b0;
		end else begin
			ls_en   <= (ls_cnt == LS_DIV_COUNT - 8'h01);
			osc_en  <= (osc_cnt == OSC_DIV_COUNT - 8'h01);
			// Wrap each divider at its terminal count
			ls_cnt  <= (ls_cnt == LS_DIV_COUNT - 8'h01) ? 8'h00 : ls_cnt + 8'h01;
			osc_cnt <= (osc_cnt == OSC_DIV_COUNT - 8'h01) ? 8'h00 : osc_cnt + 8'h01;
		end
	end

	// Sampling strobes: triggers use oscillator only when it clocks the channel
	assign clk_sel            = config_reg[B_CLK_HI:B_CLK_LO];
	assign pin_raw[PIN_EV0]   = EVENT_INPUT_ZERO_IN;
	assign pin_raw[PIN_EV1]   = EVENT_INPUT_ONE_IN;
	assign pin_raw[PIN_EXT_CLK] = EXTERNAL_TIMER_CLOCK_PIN_IN;
	assign pin_smp[PIN_EV0]   = (clk_sel == CLK_OSC) ? osc_en : ls_en;
	assign pin_smp[PIN_EV1]   = (clk_sel == CLK_OSC) ? osc_en : ls_en;
	assign pin_smp[PIN_EXT_CLK] = 1'b1;

	// Synchroniser bank for the pins
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			pin_edge_sampler u_sampler (
				.clk_in       (CLOCK_IN),
				.srst_in      (SRST_IN),
				.pin_in       (pin_raw[gi]),
				.sample_en_in (pin_smp[gi]),
				.rise_out     (pin_rise[gi]),
				.fall_out     (pin_fall[gi])
			);
		end
	endgenerate

	// Selected trigger pin edges
	assign trig_rise = trig_sel_eff ? pin_rise[PIN_EV1] : pin_rise[PIN_EV0];
	assign trig_fall = trig_sel_eff ? pin_fall[PIN_EV1] : pin_fall[PIN_EV0];

	// Operating clock source; reserved code gives no clock
	always_comb begin
		case (clk_sel)
			CLK_LOW_SPEED: src_en = ls_en;
			CLK_OSC:       src_en = osc_en;
			CLK_EXT_PIN:   src_en = pin_rise[PIN_EXT_CLK];
			default:       src_en = 1'b0;
		endcase
	end

	// Divider mask: 2^n - 1, unused code behaves as 1/1
	always_comb begin
		if (div_eff == DIV_UNUSED) begin
			div_mask = 7'h00;
		end else begin
			div_mask = 7'((8'h01 << div_eff) - 8'h01);
		end
	end
	assign tick = src_en & ((prescale & div_mask) == div_mask);

	// Prescaler advances on every source enable
	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN || cnt_write) begin
			prescale <= 7'h00;
		end else if (src_en) begin
			prescale <= prescale + 7'h01;
		end
	end

	// External trigger decode per start mode and edge
	always_comb begin
		ext_start = 1'b0;
		ext_stop  = 1'b0;
		ext_clear = 1'b0;
		case (stm_eff)
			STM_SW_EXT, STM_EXT: begin
				// Start on one edge, stop and clear on the other
				case (edge_eff)
					EDGE_RISE: begin
						ext_start = trig_rise;
						ext_stop  = trig_fall;
					end
					EDGE_FALL: begin
						ext_start = trig_fall;
						ext_stop  = trig_rise;
					end
					default:   ext_start = 1'b0; // Edge codes that disable start
				endcase
			end
			STM_SW_CLR: begin
				// Clear edge chosen by field; inhibit while flag high
				case (edge_eff)
					EDGE_RISE: ext_clear = trig_fall;
					EDGE_FALL: ext_clear = trig_rise;
					EDGE_BOTH: ext_clear = trig_rise | trig_fall;
					default:   ext_clear = 1'b0;
				endcase
				if (output_flag && clr_inh_eff) begin
					ext_clear = 1'b0;
				end
			end
			default: ext_start = 1'b0; // Software start only
		endcase
	end

	// Compare points
	assign per_match  = counting & tick & (counter == PERIOD_IN);
	assign duty_match = counting & tick & (counter == DUTY_IN);

	// Run bit and counting state
	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			run_control <= 1'b0;
			state       <= ST_STOPPED;
		end else begin
			case (state)
				ST_STOPPED: begin
					// Software start allowed except in external-only mode
					if ((sw_start && stm_eff != STM_EXT) || ext_start) begin
						run_control <= 1'b1;
						state       <= ST_COUNTING;
					end
				end
				ST_COUNTING: begin
					// Stop by software, external edge or end of one shot
					if (sw_stop || ext_stop || (per_match && one_shot_eff)) begin
						run_control <= 1'b0;
						state       <= ST_STOPPED;
					end
				end
				default: begin
					run_control <= 1'b0;
					state       <= ST_STOPPED;
				end
			endcase
		end
	end

	// Counter: cleared by writes and external clear or stop
	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			counter <= 16'h0000;
		end else if (cnt_write || ext_stop || ext_clear || per_match) begin
			counter <= 16'h0000;
		end else if (counting && tick) begin
			counter <= counter + 16'h0001;
		end
	end

	// Output flag: set at period start, cleared at duty match
	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			output_flag <= 1'b1;
		end else if (cnt_write || ext_stop || ext_clear) begin
			output_flag <= 1'b1;
		end else if (per_match) begin
			output_flag <= 1'b1;
		end else if (duty_match) begin
			output_flag <= 1'b0;
		end else if (!counting && susp_return) begin
			output_flag <= 1'b1;
		end
	end

	// Pins, interrupt pulse and status mirror
	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			PWM_OUT      <= 1'b1;
			IRQ_OUT      <= 1'b0;
			COUNTING_OUT <= 1'b0;
		end else begin
			PWM_OUT      <= output_flag ? init_out : ~init_out;
			IRQ_OUT      <= irq_hit(config_reg[B_IRQ_HI:B_IRQ_LO], per_match,
				duty_match);
			COUNTING_OUT <= counting;
		end
	end

	// Writable control registers
	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			config_reg <= RST_CONFIG;
			trig_reg   <= RST_TRIG_MODE;
		end else if (wr_go) begin
			if (bus_idx == IDX_CONFIG) begin
				config_reg <= AVS_WRITEDATA_IN[7:0];
			end
			if (bus_idx == IDX_TRIG_MODE) begin
				trig_reg <= AVS_WRITEDATA_IN[7:0] & MASK_TRIG;
			end
		end
	end

	// Read mux; unmapped and reserved bits read zero
	always_comb begin
		rd_byte = 8'h00;
		case (bus_idx)
			IDX_COUNT_LO:  rd_byte = counter[7:0];
			IDX_COUNT_HI:  rd_byte = counter[15:8];
			IDX_CONFIG:    rd_byte = config_reg;
			IDX_RUN_STAT: begin
				rd_byte[B_STATUS] = counting;
				rd_byte[B_FLAG]   = output_flag;
				rd_byte[B_RUN]    = run_control;
			end
			IDX_TRIG_MODE: rd_byte = trig_reg;
			default:       rd_byte = 8'h00;
		endcase
	end

	// Avalon handshake: one wait cycle, then complete
	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			AVS_WAITREQUEST_OUT <= 1'b1;
			AVS_READDATA_OUT    <= 32'h0000_0000;
		end else if (bus_req && AVS_WAITREQUEST_OUT) begin
			AVS_WAITREQUEST_OUT <= 1'b0;
			AVS_READDATA_OUT    <= {24'h00_0000, rd_byte};
		end else begin
			AVS_WAITREQUEST_OUT <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// file: pwm_channel_control_props.sv
// Purpose: Port checks for the PWM channel control block
// Assumes: Sees only the top module ports
// Notes:   Bound into every instance of the block
`timescale 1ns/10ps
`default_nettype none
module pwm_channel_control_props
	import pwm_channel_pkg::*;
(
	input wire logic              CLOCK_IN,            // System clock
	input wire logic              SRST_IN,             // Reset
	input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,      // Byte address
	input wire logic              AVS_READ_IN,         // Read
	input wire logic              AVS_WRITE_IN,        // Write
	input wire logic [31:0]       AVS_READDATA_OUT,    // Read data
	input wire logic              AVS_WAITREQUEST_OUT, // Busy
	input wire logic              PWM_OUT,             // Output pin
	input wire logic              IRQ_OUT,             // Interrupt
	input wire logic              COUNTING_OUT         // Status copy
);
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (SRST_IN);
	logic req;                                         // Any request
	assign req = AVS_READ_IN | AVS_WRITE_IN;
	// One low cycle, then high again
	sequence s_answer;
		!AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
	endsequence
	a_answer_once: assert property (req && AVS_WAITREQUEST_OUT |=> s_answer)
		else $error("access not answered in one cycle");
	a_idle_quiet: assert property (!req && AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
		else $error("answer without request");
	a_upper_zero: assert property (!AVS_WAITREQUEST_OUT |-> AVS_READDATA_OUT[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_trig_reserved: assert property (!AVS_WAITREQUEST_OUT && AVS_READ_IN
		&& AVS_ADDRESS_IN[17:2] == IDX_TRIG_MODE |-> (AVS_READDATA_OUT[7:0] & ~MASK_TRIG) == 8'h00)
		else $error("reserved trigger bits set");
	a_stat_reserved: assert property (!AVS_WAITREQUEST_OUT && AVS_READ_IN
		&& AVS_ADDRESS_IN[17:2] == IDX_RUN_STAT |-> AVS_READDATA_OUT[5:1] == 5'h00)
		else $error("reserved status bits set");
	a_irq_pulse: assert property (IRQ_OUT |=> !IRQ_OUT)
		else $error("interrupt longer than one cycle");
	a_reset_outputs: assert property ($fell(SRST_IN) |-> !COUNTING_OUT && PWM_OUT && !IRQ_OUT)
		else $error("outputs wrong after reset");
	a_stopped_quiet: assert property (!COUNTING_OUT [*3] |-> !IRQ_OUT)
		else $error("interrupt while stopped");
endmodule
bind pwm_channel_control pwm_channel_control_props u_props (.CLOCK_IN(CLOCK_IN),
	.SRST_IN(SRST_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
	.AVS_WRITE_IN(AVS_WRITE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
	.AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .PWM_OUT(PWM_OUT), .IRQ_OUT(IRQ_OUT),
	.COUNTING_OUT(COUNTING_OUT));
`default_nettype wire

// file: pwm_channel_pkg.sv
// Purpose: Shared constants for one 16-bit PWM channel control block
// Assumes: Avalon-MM byte address = register index * 4, data in bits 7:0
// Notes:   Prescaler counts and the source clock rates are plain defaults
package pwm_channel_pkg;

	// Bus geometry
	localparam int          ADDR_W        = 18;          // Byte address width
	localparam int          IDX_W         = 16;          // Register index width
	// Register indices (byte address is four times the index)
	localparam logic [15:0] IDX_COUNT_LO  = 16'hf4d4;    // Counter low byte
	localparam logic [15:0] IDX_COUNT_HI  = 16'hf4d5;    // Counter high byte
	localparam logic [15:0] IDX_CONFIG    = 16'hf4d6;    // pwm_b_config
	localparam logic [15:0] IDX_RUN_STAT  = 16'hf4d7;    // pwm_b_run_status
	localparam logic [15:0] IDX_TRIG_MODE = 16'hf4d8;    // pwm_b_trigger_mode
	// Reset values
	localparam logic [7:0]  RST_CONFIG    = 8'h00;
	localparam logic [7:0]  RST_RUN_STAT  = 8'h40;
	localparam logic [7:0]  RST_TRIG_MODE = 8'h00;
	// pwm_b_config fields
	localparam int          B_CLR_INH     = 7;           // clear_inhibit
	localparam int          B_SUSP_LVL    = 6;           // suspend_level_select
	localparam int          B_INIT_LVL    = 5;           // initial_level
	localparam int          B_POLARITY    = 4;           // output_polarity
	localparam int          B_IRQ_HI      = 3;           // irq_point_hi
	localparam int          B_IRQ_LO      = 2;           // irq_point_lo
	localparam int          B_CLK_HI      = 1;           // clock_select_hi
	localparam int          B_CLK_LO      = 0;           // clock_select_lo
	// pwm_b_run_status fields
	localparam int          B_STATUS      = 7;           // counting_status
	localparam int          B_FLAG        = 6;           // output_flag
	localparam int          B_RUN         = 0;           // run_control
	// pwm_b_trigger_mode fields
	localparam int          B_ONE_SHOT    = 6;           // one_shot_select
	localparam int          B_TRIG_PIN    = 4;           // trigger_pin_select
	localparam int          B_STM_HI      = 3;           // start_mode_hi
	localparam int          B_STM_LO      = 2;           // start_mode_lo
	localparam int          B_EDGE_HI     = 1;           // trigger_edge_hi
	localparam int          B_EDGE_LO     = 0;           // trigger_edge_lo
	// Writable masks; everything else reads zero
	localparam logic [7:0]  MASK_TRIG     = 8'h5f;
	// Clock source codes
	localparam logic [1:0]  CLK_LOW_SPEED = 2'h0;
	localparam logic [1:0]  CLK_OSC       = 2'h1;
	localparam logic [1:0]  CLK_EXT_PIN   = 2'h3;
	// Start mode codes
	localparam logic [1:0]  STM_SW        = 2'h0;
	localparam logic [1:0]  STM_SW_EXT    = 2'h1;
	localparam logic [1:0]  STM_EXT       = 2'h2;
	localparam logic [1:0]  STM_SW_CLR    = 2'h3;
	// Edge codes
	localparam logic [1:0]  EDGE_OFF      = 2'h0;
	localparam logic [1:0]  EDGE_RISE     = 2'h1;
	localparam logic [1:0]  EDGE_FALL     = 2'h2;
	localparam logic [1:0]  EDGE_BOTH     = 2'h3;
	// Divider settings
	localparam logic [2:0]  DIV_UNUSED    = 3'h7;        // Treated as 1/1
	// Source clock enables derived from the 250 MHz system clock
	localparam logic [7:0]  LS_DIV_COUNT  = 8'h40;       // Low-speed enable period
	localparam logic [7:0]  OSC_DIV_COUNT = 8'h02;       // Oscillator enable period
	// Pins sampled by the synchroniser bank
	localparam int          PIN_EV0       = 0;
	localparam int          PIN_EV1       = 1;
	localparam int          PIN_EXT_CLK   = 2;
	localparam int          NUM_PINS      = 3;

	// Counting state, one-hot
	typedef enum logic [1:0] {
		ST_STOPPED  = 2'b01,
		ST_COUNTING = 2'b10
	} count_state_e;

endpackage

// file: pwm_event_source.sv
// Purpose: Far-side model of the event pins and external clock pin
// Assumes: Pins change just after a rising system clock edge
// Notes:   External clock stands low while disabled
`timescale 1ns/10ps
`default_nettype none
module pwm_event_source (
	input  wire logic clk_in,      // System clock
	output var  logic ev0_out,     // Event input zero
	output var  logic ev1_out,     // Event input one
	output var  logic ext_clk_out  // External clock pin
);
	logic ext_run;                 // External clock enable
	int   cnt;                     // Half period counter
	initial begin
		ext_run = 1'b0;
		cnt = 0;
		ev0_out = 1'b0;
		ev1_out = 1'b0;
		ext_clk_out = 1'b0;
	end
	// Slow external clock, three cycles per half
	always @(posedge clk_in) begin
		cnt <= (cnt == 2) ? 0 : cnt + 1;
		if (!ext_run)
			ext_clk_out <= 1'b0;
		else if (cnt == 2)
			ext_clk_out <= ~ext_clk_out;
	end
	// Drive one event pin after an edge
	task automatic set_pin(input logic which, input logic lvl);
		@(posedge clk_in);
		if (which)
			ev1_out <= lvl;
		else
			ev0_out <= lvl;
	endtask
endmodule
`default_nettype wire

// file: test_pwm_channel_control.sv
// Purpose: Register-level tests of the PWM channel control block
// Assumes: One wait cycle per access, oscillator enable every 2 cycles
// Notes:   Pins come from the event source model
`timescale 1ns/10ps
`default_nettype none
module test_pwm_channel_control import pwm_channel_pkg::*;;
	logic        clk, srst, rd, wr, irq, pwm, cnt, ev0, ev1, ext, cpl, waitreq;
	logic [17:0] addr;
	logic [31:0] wdata, rdata;
	logic [15:0] period, duty;
	logic [2:0]  div;
	logic [7:0]  d;                // Last read byte
	int          mismatches, cmp_count;
	pwm_event_source src (.clk_in(clk), .ev0_out(ev0), .ev1_out(ev1), .ext_clk_out(ext));
	pwm_channel_control dut (.CLOCK_IN(clk), .SRST_IN(srst), .AVS_ADDRESS_IN(addr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
		.AVS_BYTEENABLE_IN(4'h1), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
		.PERIOD_IN(period), .DUTY_IN(duty), .DIVIDER_SELECT_IN(div),
		.EVENT_INPUT_ZERO_IN(ev0), .EVENT_INPUT_ONE_IN(ev1),
		.EXTERNAL_TIMER_CLOCK_PIN_IN(ext), .PAIR_COUPLED_MODE_IN(cpl),
		.PARTNER_CLEAR_INHIBIT_IN(1'b0), .PARTNER_RUN_IN(1'b0), .PARTNER_ONE_SHOT_IN(1'b0),
		.PARTNER_TRIGGER_PIN_IN(1'b1), .PARTNER_DIVIDER_IN(div), .PWM_OUT(pwm),
		.IRQ_OUT(irq), .COUNTING_OUT(cnt));
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One Avalon access, held until waitrequest low
	task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] v);
		@(posedge clk);
		addr <= {i, 2'b00};
		wdata <= {24'h0, v};
		wr <= w;
		rd <= ~w;
		do @(posedge clk); while (waitreq !== 1'b0);
		d = rdata[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic get(input logic [15:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00);
		chk(d, e);
	endtask
	// Bounded wait for a level
	task automatic waitv(ref logic s, input logic v);
		int n;
		for (n = 0; n < 400 && s !== v; n++) @(posedge clk);
		chk({7'h0, s}, {7'h0, v});
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic print_verdict;
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		print_verdict();
	end
	// Main sequence
	initial begin
		srst = 1'b1; rd = 1'b0; wr = 1'b0; addr = '0; wdata = '0; cpl = 1'b0;
		period = 16'h0004; duty = 16'h0002; div = 3'h7; mismatches = 0; cmp_count = 0;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		get(IDX_CONFIG, RST_CONFIG);
		get(IDX_RUN_STAT, RST_RUN_STAT);
		get(IDX_TRIG_MODE, RST_TRIG_MODE);
		bus(1'b1, IDX_TRIG_MODE, 8'hff);
		get(IDX_TRIG_MODE, MASK_TRIG);
		bus(1'b1, 16'hf4d9, 8'hff);
		get(16'hf4d9, 8'h00);
		bus(1'b1, IDX_TRIG_MODE, 8'h00);
		done("registers");
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, IDX_CONFIG, {2'b00, k[1:0], 4'h0});
			repeat (3) @(posedge clk);
			chk({7'h0, pwm}, {7'h0, ~(k[1] ^ k[0])});
		end
		done("levels");
		bus(1'b1, IDX_CONFIG, 8'h01);
		bus(1'b1, IDX_RUN_STAT, 8'h01);
		bus(1'b0, IDX_RUN_STAT, 8'h00);
		chk(d & 8'h81, 8'h81);
		waitv(irq, 1'b1);
		repeat (40) @(posedge clk);
		chk({7'h0, cnt}, 8'h01);
		bus(1'b1, IDX_RUN_STAT, 8'h00);
		bus(1'b0, IDX_RUN_STAT, 8'h00);
		chk(d & 8'h81, 8'h00);
		bus(1'b1, IDX_COUNT_HI, 8'h5a);
		get(IDX_COUNT_LO, 8'h00);
		bus(1'b0, IDX_RUN_STAT, 8'h00);
		chk(d & 8'h40, 8'h40);
		bus(1'b1, IDX_TRIG_MODE, 8'h40);
		bus(1'b1, IDX_RUN_STAT, 8'h01);
		waitv(cnt, 1'b1);
		waitv(cnt, 1'b0);
		done("run");
		bus(1'b1, IDX_TRIG_MODE, 8'h00);
		bus(1'b1, IDX_CONFIG, 8'h03);
		src.ext_run <= 1'b1;
		bus(1'b1, IDX_RUN_STAT, 8'h01);
		waitv(irq, 1'b1);
		bus(1'b1, IDX_RUN_STAT, 8'h00);
		src.ext_run <= 1'b0;
		duty <= 16'h0000;
		bus(1'b1, IDX_CONFIG, 8'h07);
		bus(1'b1, IDX_COUNT_LO, 8'h00);
		bus(1'b1, IDX_RUN_STAT, 8'h01);
		src.ext_run <= 1'b1;
		repeat (4) @(posedge clk);
		src.ext_run <= 1'b0;
		waitv(irq, 1'b1);
		bus(1'b1, IDX_RUN_STAT, 8'h00);
		bus(1'b0, IDX_RUN_STAT, 8'h00);
		chk(d & 8'h40, 8'h00);
		bus(1'b1, IDX_CONFIG, 8'h47);
		bus(1'b0, IDX_RUN_STAT, 8'h00);
		chk(d & 8'h40, 8'h40);
		bus(1'b1, IDX_CONFIG, 8'h01);
		bus(1'b1, IDX_TRIG_MODE, 8'h19);
		src.set_pin(1'b0, 1'b1);
		repeat (20) @(posedge clk);
		chk({7'h0, cnt}, 8'h00);
		src.set_pin(1'b1, 1'b1);
		waitv(cnt, 1'b1);
		src.set_pin(1'b1, 1'b0);
		waitv(cnt, 1'b0);
		cpl <= 1'b1;
		src.set_pin(1'b1, 1'b1);
		repeat (20) @(posedge clk);
		chk({7'h0, cnt}, 8'h00);
		done("triggers");
		print_verdict();
	end
endmodule
`default_nettype wire
